// ### timer16_map.svh
// Register selects, mode codes, fixed ceilings and reset values of the 16-bit timer.
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// ==========================================================
// CPU byte locations
`define T16_SEL_CNT_LO 2'h0
`define T16_SEL_CNT_HI 2'h1
`define T16_SEL_CAP_LO 2'h2
`define T16_SEL_CAP_HI 2'h3

// ==========================================================
// Waveform mode codes
`define T16_MODE_NORMAL   4'h0
`define T16_MODE_PC8      4'h1
`define T16_MODE_PC9      4'h2
`define T16_MODE_PC10     4'h3
`define T16_MODE_CTC_OCA  4'h4
`define T16_MODE_FAST8    4'h5
`define T16_MODE_FAST9    4'h6
`define T16_MODE_FAST10   4'h7
`define T16_MODE_PFC_ICR  4'h8
`define T16_MODE_PFC_OCA  4'h9
`define T16_MODE_PC_ICR   4'hA
`define T16_MODE_PC_OCA   4'hB
`define T16_MODE_CTC_ICR  4'hC
`define T16_MODE_FAST_ICR 4'hE
`define T16_MODE_FAST_OCA 4'hF

// ==========================================================
// Fixed ceilings and reset values
`define T16_TOP_8BIT  16'h00FF
`define T16_TOP_9BIT  16'h01FF
`define T16_TOP_10BIT 16'h03FF
`define T16_MAX       16'hFFFF
`define T16_FLOOR     16'h0000
`define T16_WORD_RST  16'h0000
`define T16_BYTE_RST  8'h00
`define T16_CS_STOP   3'h0

// ==========================================================
// Noise filter depth in system clock samples
`define T16_FILTER_DEPTH 4

`endif

// ### timer16_pkg.sv
// Shared types of the 16-bit timer.
package timer16_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

// ### capture_if.sv
// Signals between the timer core and its capture front end.
`timescale 1ns/1ns
`default_nettype none
interface capture_if;
  logic pin_level;
  logic comp_level;
  logic source_sel;
  logic filter_en;
  logic rising;
  logic enable;
  logic trig;
  modport front (input pin_level, comp_level, source_sel, filter_en, rising, enable,
                 output trig);
  modport core  (output pin_level, comp_level, source_sel, filter_en, rising, enable,
                 input trig);
endinterface
`default_nettype wire

// ### capture_front.sv
// Capture input synchroniser, noise filter and edge detector.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_map.svh"
module capture_front (
  input wire logic      clk,  // System clock.
  input wire logic      srst, // Synchronous reset, active high.
  capture_if.front      cif   // Core side signals.
);
  logic                         pin_meta_reg;
  logic                         pin_sync_reg;
  logic [`T16_FILTER_DEPTH-1:0] hist_reg;
  logic                         filt_reg;
  logic                         prev_reg;
  wire logic                    src_level;
  wire logic                    all_high;
  wire logic                    all_low;
  wire logic                    filt_next;
  wire logic                    level;

  // The comparator is on-chip and synchronous, so only the pin is resynchronised.
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= cif.pin_level;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Switching source can itself produce an edge; that is left visible on purpose.
  assign src_level = cif.source_sel ? cif.comp_level : pin_sync_reg;

  // ==========================================================
  // Noise filter, sampled every system clock regardless of the timer tick
  always_ff @(posedge clk) begin
    if (srst) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[`T16_FILTER_DEPTH-2:0], src_level};
      filt_reg <= filt_next;
      prev_reg <= level;
    end
  end

  assign all_high  = &hist_reg;
  assign all_low   = ~|hist_reg;
  assign filt_next = all_high ? 1'b1 : (all_low ? 1'b0 : filt_reg);
  // The filtered level trails the first history bit by four clocks.
  assign level     = cif.filter_en ? filt_reg : hist_reg[0];

  // ==========================================================
  // Edge detector
  assign cif.trig = cif.enable &
                    (cif.rising ? (level & ~prev_reg) : (~level & prev_reg));
endmodule
`default_nettype wire

// ### timer16_counter_input_capture.sv
// Counter core and input capture unit of the 16-bit timer.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_map.svh"
module timer16_counter_input_capture
  import timer16_pkg::*;
(
  input  wire logic       clk,                   // System clock, 25 MHz.
  input  wire logic       srst,                  // Synchronous reset, active high.

  input  wire logic [1:0] cpu_sel,               // Byte location select.
  input  wire logic       cpu_wr,                // Write strobe, one cycle.
  input  wire logic       cpu_rd,                // Read strobe, one cycle.
  input  wire byte_t      cpu_wdata,             // Write data.
  output var  byte_t      cpu_rdata,             // Read data, valid after the strobe.
  output var  byte_t      holding_byte,          // Shared high-byte holding register.

  input  wire logic [3:0] waveform_mode_field,   // Counting sequence select.
  input  wire logic [2:0] clock_select_field,    // Zero stops the timer.
  input  wire logic       source_tick,           // Tick of the selected clock source.
  input  wire word_t      compare_a_value,       // Compare A value for ceiling modes.

  input  wire logic       capture_source_sel,    // 0 pin, 1 comparator.
  input  wire logic       capture_pin,           // Capture pin pad level.
  input  wire logic       port_dir_out,          // Port drives the capture pin.
  input  wire logic       port_out_level,        // Port output level of that pin.
  input  wire logic       comparator_output,     // Analog comparator output.
  input  wire logic       capture_filter_enable, // Noise filter on.
  input  wire logic       capture_edge_rising,   // 1 rising, 0 falling.

  input  wire logic       capture_irq_enable,    // Capture interrupt enable.
  input  wire logic       overflow_irq_enable,   // Overflow interrupt enable.
  input  wire logic       capture_flag_clear,    // Write-one clear of capture flag.
  input  wire logic       overflow_flag_clear,   // Write-one clear of overflow flag.
  input  wire logic       capture_irq_ack,       // Capture interrupt serviced.
  input  wire logic       overflow_irq_ack,      // Overflow interrupt serviced.

  output var  word_t      counter_value,         // Counter register.
  output var  word_t      capture_value,         // Capture register.
  output logic            timer_tick,            // Qualified timer tick.
  output logic            count_floor,           // Counter is zero.
  output logic            count_ceiling,         // Counter equals the ceiling.
  output logic            overflow_flag,         // Overflow flag.
  output logic            capture_flag,          // Capture flag.
  output logic            overflow_irq,          // Overflow interrupt request.
  output logic            capture_irq            // Capture interrupt request.
);

  // ==========================================================
  // State
  word_t      counter_reg;
  word_t      counter_next;
  word_t      capture_reg;
  word_t      capture_next;
  byte_t      hold_reg;
  byte_t      hold_next;
  byte_t      rdata_reg;
  byte_t      rdata_next;
  // Direction is held at up outside dual-slope modes.
  dir_t       dir_reg;
  dir_t       dir_next;
  logic       ovf_flag_reg;
  logic       ovf_flag_next;
  logic       cap_flag_reg;
  logic       cap_flag_next;

  capture_if  cif ();

  // ==========================================================
  // CPU decode
  wire logic  sel_cnt_lo;
  wire logic  sel_cnt_hi;
  wire logic  sel_cap_lo;
  wire logic  sel_cap_hi;
  wire logic  wr_cnt_lo;
  wire logic  wr_high;
  wire logic  wr_cap_lo;
  wire logic  rd_cnt_lo;
  wire logic  rd_cap_lo;
  wire byte_t rd_mux;

  assign sel_cnt_lo = (cpu_sel == `T16_SEL_CNT_LO);
  assign sel_cnt_hi = (cpu_sel == `T16_SEL_CNT_HI);
  assign sel_cap_lo = (cpu_sel == `T16_SEL_CAP_LO);
  assign sel_cap_hi = (cpu_sel == `T16_SEL_CAP_HI);

  assign wr_cnt_lo  = cpu_wr & sel_cnt_lo;
  assign wr_high    = cpu_wr & (sel_cnt_hi | sel_cap_hi);
  assign rd_cnt_lo  = cpu_rd & sel_cnt_lo;
  assign rd_cap_lo  = cpu_rd & sel_cap_lo;

  // High locations always answer from the holding register, never the live word.
  assign rd_mux = sel_cnt_lo ? counter_reg[7:0] :
                  sel_cap_lo ? capture_reg[7:0] :
                  hold_reg;
  // Read data holds until the next read strobe.
  assign rdata_next = cpu_rd ? rd_mux : rdata_reg;

  // ==========================================================
  // Mode decode
  wire logic  mode_icr_top;
  wire logic  mode_oca_top;
  wire logic  mode_updown;
  wire logic  mode_fast;
  wire logic  mode_top8;
  wire logic  mode_top9;
  wire logic  mode_top10;
  wire word_t ceiling_value;
  wire logic  at_ceiling;
  wire logic  at_floor;

  assign mode_icr_top = (waveform_mode_field == `T16_MODE_PFC_ICR) |
                        (waveform_mode_field == `T16_MODE_PC_ICR)  |
                        (waveform_mode_field == `T16_MODE_CTC_ICR) |
                        (waveform_mode_field == `T16_MODE_FAST_ICR);
  assign mode_oca_top = (waveform_mode_field == `T16_MODE_CTC_OCA) |
                        (waveform_mode_field == `T16_MODE_PFC_OCA) |
                        (waveform_mode_field == `T16_MODE_PC_OCA)  |
                        (waveform_mode_field == `T16_MODE_FAST_OCA);
  assign mode_updown  = (waveform_mode_field == `T16_MODE_PC8)     |
                        (waveform_mode_field == `T16_MODE_PC9)     |
                        (waveform_mode_field == `T16_MODE_PC10)    |
                        (waveform_mode_field == `T16_MODE_PFC_ICR) |
                        (waveform_mode_field == `T16_MODE_PFC_OCA) |
                        (waveform_mode_field == `T16_MODE_PC_ICR)  |
                        (waveform_mode_field == `T16_MODE_PC_OCA);
  assign mode_fast    = (waveform_mode_field == `T16_MODE_FAST8)    |
                        (waveform_mode_field == `T16_MODE_FAST9)    |
                        (waveform_mode_field == `T16_MODE_FAST10)   |
                        (waveform_mode_field == `T16_MODE_FAST_ICR) |
                        (waveform_mode_field == `T16_MODE_FAST_OCA);
  assign mode_top8    = (waveform_mode_field == `T16_MODE_PC8) |
                        (waveform_mode_field == `T16_MODE_FAST8);
  assign mode_top9    = (waveform_mode_field == `T16_MODE_PC9) |
                        (waveform_mode_field == `T16_MODE_FAST9);
  assign mode_top10   = (waveform_mode_field == `T16_MODE_PC10) |
                        (waveform_mode_field == `T16_MODE_FAST10);

  // Code 13 is reserved and counts as the normal mode.
  // Register ceilings are followed live, with no buffering.
  // A ceiling set below the count lets the counter wrap first.
  assign ceiling_value = mode_icr_top ? capture_reg :
                         mode_oca_top ? compare_a_value :
                         mode_top8    ? `T16_TOP_8BIT :
                         mode_top9    ? `T16_TOP_9BIT :
                         mode_top10   ? `T16_TOP_10BIT :
                         `T16_MAX;

  // Both compares use the registered count.
  assign at_ceiling = (counter_reg == ceiling_value);
  assign at_floor   = (counter_reg == `T16_FLOOR);

  // ==========================================================
  // Counting
  wire logic  tick;
  wire logic  turn_down;
  wire word_t count_up;
  wire word_t count_down;
  wire word_t counted;
  wire logic  ovf_event;
  wire logic  clear_at_top;
  wire logic  ovf_dual;
  wire logic  ovf_fast;
  wire logic  ovf_max;

  // The prescaler is outside; each source tick is one clock wide.
  assign tick = (clock_select_field != `T16_CS_STOP) & source_tick;

  assign count_up   = counter_reg + 16'h0001;
  assign count_down = counter_reg - 16'h0001;

  // In dual-slope modes the direction turns at the ceiling and at the floor.
  assign turn_down = (dir_reg == DIR_DOWN) ? ~at_floor : at_ceiling;

  // Normal mode needs no explicit clear: the increment wraps past the maximum.
  assign clear_at_top = (mode_fast | mode_oca_top | mode_icr_top) & at_ceiling;
  assign counted      = mode_updown  ? (turn_down ? count_down : count_up) :
                        clear_at_top ? `T16_WORD_RST : count_up;

  // Overflow marks the floor going down, the fast ceiling, or the maximum.
  assign ovf_dual  = mode_updown & (dir_reg == DIR_DOWN) & at_floor;
  assign ovf_fast  = mode_fast & at_ceiling;
  assign ovf_max   = ~mode_updown & ~mode_fast & (counter_reg == `T16_MAX);
  // A CPU write replaces the count, so the overflow it would have caused is dropped.
  assign ovf_event = tick & ~wr_cnt_lo & (ovf_dual | ovf_fast | ovf_max);

  always_comb begin
    counter_next = counter_reg;
    dir_next     = dir_reg;
    if (wr_cnt_lo) begin
      counter_next = {hold_reg, cpu_wdata};
    end else if (tick) begin
      counter_next = counted;
    end
    // A counter write keeps the direction.
    if (!mode_updown) begin
      dir_next = DIR_UP;
    end else if (tick && !wr_cnt_lo) begin
      dir_next = turn_down ? DIR_DOWN : DIR_UP;
    end
  end

  // ==========================================================
  // Holding register and capture register
  wire logic  cap_write;

  // The capture word is only a writable ceiling while it actually serves as one.
  assign cap_write = cpu_wr & sel_cap_lo & mode_icr_top;

  // Only one strobe is high at a time, so this order never matters.
  always_comb begin
    hold_next = hold_reg;
    if (rd_cnt_lo) begin
      hold_next = counter_reg[15:8];
    end else if (rd_cap_lo) begin
      hold_next = capture_reg[15:8];
    end else if (wr_high) begin
      hold_next = cpu_wdata;
    end
  end

  always_comb begin
    capture_next = capture_reg;
    if (cap_write) begin
      capture_next = {hold_reg, cpu_wdata};
    end else if (cif.trig) begin
      capture_next = counter_reg;
    end
  end

  // ==========================================================
  // Flags: a set in the same cycle as a clear wins
  wire logic  cap_flag_clr;
  wire logic  ovf_flag_clr;

  // Servicing the interrupt and writing a one clear a flag alike.
  assign cap_flag_clr = capture_flag_clear | capture_irq_ack;
  assign ovf_flag_clr = overflow_flag_clear | overflow_irq_ack;

  always_comb begin
    cap_flag_next = cif.trig | (cap_flag_reg & ~cap_flag_clr);
    ovf_flag_next = ovf_event | (ovf_flag_reg & ~ovf_flag_clr);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      counter_reg  <= `T16_WORD_RST;
      capture_reg  <= `T16_WORD_RST;
      hold_reg     <= `T16_BYTE_RST;
      rdata_reg    <= `T16_BYTE_RST;
      dir_reg      <= DIR_UP;
      ovf_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else begin
      counter_reg  <= counter_next;
      capture_reg  <= capture_next;
      hold_reg     <= hold_next;
      dir_reg      <= dir_next;
      ovf_flag_reg <= ovf_flag_next;
      cap_flag_reg <= cap_flag_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ==========================================================
  // Capture front end
  wire logic  pad_level;

  // The pad reads back what the port drives, so software can fire a capture.
  assign pad_level      = port_dir_out ? port_out_level : capture_pin;
  assign cif.pin_level  = pad_level;
  assign cif.comp_level = comparator_output;
  assign cif.source_sel = capture_source_sel;
  assign cif.filter_en  = capture_filter_enable;
  assign cif.rising     = capture_edge_rising;
  // Modes that use the capture word as ceiling still track the level but fire nothing.
  assign cif.enable     = ~mode_icr_top;

  capture_front i_capture_front (
    .clk  (clk),
    .srst (srst),
    .cif  (cif)
  );

  // ==========================================================
  // Outputs
  assign cpu_rdata     = rdata_reg;
  assign holding_byte  = hold_reg;
  assign counter_value = counter_reg;
  assign capture_value = capture_reg;
  assign timer_tick    = tick;
  assign count_floor   = at_floor;
  assign count_ceiling = at_ceiling;
  assign overflow_flag = ovf_flag_reg;
  assign capture_flag  = cap_flag_reg;
  assign overflow_irq  = ovf_flag_reg & overflow_irq_enable;
  assign capture_irq   = cap_flag_reg & capture_irq_enable;

endmodule
`default_nettype wire

// ### timer16_monitor.sv
// Port-level assertions for the 16-bit timer counter and capture unit.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_map.svh"
module timer16_monitor
  import timer16_pkg::*;
(
  input wire logic       clk,                 // Clock.
  input wire logic       srst,                // Reset.
  input wire logic [1:0] cpu_sel,             // Select.
  input wire logic       cpu_wr,              // Write.
  input wire logic       cpu_rd,              // Read.
  input wire byte_t      cpu_wdata,           // Data in.
  input wire byte_t      cpu_rdata,           // Data out.
  input wire byte_t      holding_byte,        // Holding.
  input wire logic [3:0] waveform_mode_field, // Mode.
  input wire logic [2:0] clock_select_field,  // Source.
  input wire word_t      counter_value,       // Counter.
  input wire word_t      capture_value,       // Capture.
  input wire logic       timer_tick,          // Tick.
  input wire logic       count_floor,         // Floor.
  input wire logic       capture_flag         // Flag.
);
  // ==========================================================
  // Decodes
  wire lo_wr   = cpu_wr && cpu_sel == `T16_SEL_CNT_LO;
  wire cap_wr  = cpu_wr && cpu_sel == `T16_SEL_CAP_LO;
  wire lo_rd   = cpu_rd && cpu_sel == `T16_SEL_CNT_LO;
  wire stopped = clock_select_field == `T16_CS_STOP;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Properties
  property p_stop; stopped && !lo_wr |=> $stable(counter_value); endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  property p_floor; count_floor == (counter_value == `T16_FLOOR); endproperty
  a_floor: assert property (p_floor) else $error("floor wrong");
  property p_up; waveform_mode_field == `T16_MODE_NORMAL && timer_tick && !lo_wr
    |=> counter_value == $past(counter_value) + 16'h0001; endproperty
  a_up: assert property (p_up) else $error("count up wrong");
  property p_load; lo_wr |=> counter_value == {$past(holding_byte), $past(cpu_wdata)};
  endproperty
  a_load: assert property (p_load) else $error("word load wrong");
  property p_lo_rd; lo_rd |=> {holding_byte, cpu_rdata} == $past(counter_value); endproperty
  a_lo_rd: assert property (p_lo_rd) else $error("low read wrong");
  property p_hi_rd; cpu_rd && cpu_sel[0] |=> cpu_rdata == $past(holding_byte); endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("high read wrong");
  property p_cap; !cap_wr ##1 capture_value != $past(capture_value) |-> capture_flag;
  endproperty
  a_cap: assert property (p_cap) else $error("capture without flag");
  property p_icr_top; waveform_mode_field == `T16_MODE_CTC_ICR && !cap_wr
    |=> $stable(capture_value); endproperty
  a_icr_top: assert property (p_icr_top) else $error("capture in ceiling mode");
endmodule

bind timer16_counter_input_capture timer16_monitor i_timer16_monitor (
  .clk, .srst, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .holding_byte,
  .waveform_mode_field, .clock_select_field, .counter_value, .capture_value,
  .timer_tick, .count_floor, .capture_flag
);
`default_nettype wire

// ### cpu_model.sv
// CPU model making byte accesses on the timer's register port.
`timescale 1ns/1ns
`default_nettype none
module cpu_model
  import timer16_pkg::*;
(
  input  wire logic       clk,       // Clock.
  output var  logic [1:0] cpu_sel,   // Select.
  output var  logic       cpu_wr,    // Write.
  output var  logic       cpu_rd,    // Read.
  output var  byte_t      cpu_wdata, // Data out.
  input  wire byte_t      cpu_rdata  // Data in.
);
  initial begin
    {cpu_sel, cpu_wr, cpu_rd, cpu_wdata} = '0;
  end
  // ==========================================================
  // Accesses
  // Released select and data lines show the inverse, so the design cannot lean on stale values.
  task automatic access(input logic w, input logic [1:0] s, input byte_t d, output byte_t q);
    cpu_sel = s;
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    @(posedge clk);
    #1;
    q = cpu_rdata;
    {cpu_wr, cpu_rd} = 2'h0;
    cpu_sel = ~s;
    cpu_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  task automatic wr16(input logic [1:0] lo, input word_t v);
    byte_t q;
    access(1'b1, lo | 2'h1, v[15:8], q);
    access(1'b1, lo, v[7:0], q);
  endtask
  task automatic rd16(input logic [1:0] lo, output word_t v);
    access(1'b0, lo, 8'h00, v[7:0]);
    access(1'b0, lo | 2'h1, 8'h00, v[15:8]);
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the 16-bit timer counter and capture unit.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_map.svh"
module tb_top
  import timer16_pkg::*;
;
  logic       clk, srst, cpu_wr, cpu_rd, source_tick, capture_source_sel, capture_pin;
  logic [1:0] cpu_sel;
  byte_t      cpu_wdata, cpu_rdata, holding_byte;
  logic [3:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  word_t      compare_a_value, counter_value, capture_value, v;
  logic       port_dir_out, port_out_level, comparator_output, capture_filter_enable;
  logic       capture_edge_rising, capture_irq_enable, overflow_irq_enable, capture_flag_clear;
  logic       overflow_flag_clear, capture_irq_ack, overflow_irq_ack, timer_tick, count_floor;
  logic       count_ceiling, overflow_flag, capture_flag, overflow_irq, capture_irq;
  byte_t      b;
  int         failures, n_tests;

  always #20 clk = ~clk;

  timer16_counter_input_capture i_timer16_counter_input_capture (
    .clk, .srst, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .holding_byte,
    .waveform_mode_field, .clock_select_field, .source_tick, .compare_a_value,
    .capture_source_sel, .capture_pin, .port_dir_out, .port_out_level, .comparator_output,
    .capture_filter_enable, .capture_edge_rising, .capture_irq_enable, .overflow_irq_enable,
    .capture_flag_clear, .overflow_flag_clear, .capture_irq_ack, .overflow_irq_ack,
    .counter_value, .capture_value, .timer_tick, .count_floor, .count_ceiling,
    .overflow_flag, .capture_flag, .overflow_irq, .capture_irq
  );
  cpu_model i_cpu_model (.clk, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata);

  // ==========================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk_w(input string s, input word_t e, input word_t g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("n_tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Counts edges from an input change to the capture flag; a hang ends the run.
  task automatic lat(input int n);
    int k;
    k = 0;
    while (capture_flag !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    if (k == 20) begin
      failures++;
      tally_and_finish();
    end else chk_w("latency", word_t'(n), word_t'(k));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_counter;
    chk_w("reset", `T16_WORD_RST, counter_value | capture_value | word_t'(holding_byte));
    chk_w("reset flags", 16'h0000, word_t'({overflow_flag, capture_flag}));
    source_tick = 1'b1;
    chk_w("no tick", 16'h0000, word_t'(timer_tick));
    i_cpu_model.wr16(`T16_SEL_CNT_LO, 16'h01FF);
    step(3);
    chk_w("held", 16'h01FF, counter_value);
    i_cpu_model.rd16(`T16_SEL_CNT_LO, v);
    chk_w("read", 16'h01FF, v);
    i_cpu_model.wr16(`T16_SEL_CAP_LO, 16'h5555);
    chk_w("cap refused", 16'h0000, capture_value);
    i_cpu_model.access(1'b1, `T16_SEL_CNT_HI, 8'hAB, b);
    i_cpu_model.access(1'b0, `T16_SEL_CAP_LO, 8'h00, b);
    i_cpu_model.access(1'b1, `T16_SEL_CNT_LO, 8'h34, b);
    chk_w("shared", 16'h0034, counter_value);
    source_tick = 1'b0;
    clock_select_field = 3'h1;
    overflow_irq_enable = 1'b1;
    i_cpu_model.wr16(`T16_SEL_CNT_LO, 16'hFFFE);
    pulse(source_tick);
    pulse(source_tick);
    chk_w("wrap", 16'h0000, counter_value);
    chk_w("floor", 16'h0001, word_t'(count_floor));
    chk_w("ovf irq", 16'h0001, word_t'(overflow_irq));
    pulse(overflow_irq_ack);
    chk_w("ovf ack", 16'h0000, word_t'(overflow_flag));
    source_tick = 1'b1;
    i_cpu_model.wr16(`T16_SEL_CNT_LO, 16'h0100);
    source_tick = 1'b0;
    chk_w("write wins", 16'h0101, counter_value);
    $display("t_counter done");
  endtask
  task automatic t_tops;
    logic [3:0] m [14] = '{4'h5, 4'h1, 4'h6, 4'h2, 4'h7, 4'h3, 4'h4, 4'h9, 4'hF, 4'hB,
                           4'hC, 4'hA, 4'hE, 4'h8};
    word_t top [14] = '{16'h00FF, 16'h00FF, 16'h01FF, 16'h01FF, 16'h03FF, 16'h03FF, 16'h0123,
                        16'h0123, 16'h0123, 16'h0123, 16'h0040, 16'h0040, 16'h0040, 16'h0040};
    word_t nxt [14] = '{16'h0000, 16'h00FE, 16'h0000, 16'h01FE, 16'h0000, 16'h03FE, 16'h0000,
                        16'h0122, 16'h0000, 16'h0122, 16'h0000, 16'h003F, 16'h0000, 16'h003F};
    logic ovf [14] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                       1'b0, 1'b1, 1'b0};
    compare_a_value = 16'h0123;
    for (int i = 0; i < 14; i++) begin
      waveform_mode_field = m[i];
      if (i == 10) i_cpu_model.wr16(`T16_SEL_CAP_LO, top[i]);
      i_cpu_model.wr16(`T16_SEL_CNT_LO, top[i] - 16'h0001);
      pulse(overflow_flag_clear);
      pulse(source_tick);
      chk_w("top", top[i], counter_value);
      chk_w("ceiling", 16'h0001, word_t'(count_ceiling));
      pulse(source_tick);
      chk_w("next", nxt[i], counter_value);
      chk_w("ovf", word_t'(ovf[i]), word_t'(overflow_flag));
    end
    waveform_mode_field = `T16_MODE_NORMAL;
    clock_select_field = `T16_CS_STOP;
    $display("t_tops done");
  endtask
  task automatic t_capture;
    i_cpu_model.wr16(`T16_SEL_CNT_LO, 16'h1234);
    capture_irq_enable = 1'b1;
    capture_edge_rising = 1'b1;
    capture_pin = 1'b1;
    lat(4);
    chk_w("cap irq", 16'h0001, word_t'(capture_irq));
    i_cpu_model.rd16(`T16_SEL_CAP_LO, v);
    chk_w("cap read", 16'h1234, v);
    pulse(capture_irq_ack);
    chk_w("cap ack", 16'h0000, word_t'(capture_flag));
    i_cpu_model.wr16(`T16_SEL_CNT_LO, 16'h2222);
    capture_edge_rising = 1'b0;
    pulse(capture_flag_clear);
    capture_pin = 1'b0;
    lat(4);
    chk_w("overwrite", 16'h2222, capture_value);
    pulse(capture_flag_clear);
    waveform_mode_field = `T16_MODE_CTC_ICR;
    capture_edge_rising = 1'b1;
    capture_pin = 1'b1;
    step(10);
    chk_w("icr top", 16'h0000, word_t'(capture_flag));
    waveform_mode_field = `T16_MODE_NORMAL;
    port_out_level = 1'b1;
    port_dir_out = 1'b1;
    step(6);
    capture_edge_rising = 1'b0;
    pulse(capture_flag_clear);
    port_out_level = 1'b0;
    lat(4);
    capture_source_sel = 1'b1;
    step(4);
    pulse(capture_flag_clear);
    capture_edge_rising = 1'b1;
    comparator_output = 1'b1;
    lat(2);
    $display("t_capture done");
  endtask
  task automatic t_filter;
    capture_source_sel = 1'b0;
    port_dir_out = 1'b0;
    capture_pin = 1'b0;
    capture_filter_enable = 1'b1;
    step(12);
    pulse(capture_flag_clear);
    capture_pin = 1'b1;
    step(3);
    capture_pin = 1'b0;
    step(12);
    chk_w("glitch", 16'h0000, word_t'(capture_flag));
    capture_pin = 1'b1;
    lat(8);
    $display("t_filter done");
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {waveform_mode_field, clock_select_field, source_tick, compare_a_value, capture_source_sel,
     capture_pin, port_dir_out, port_out_level, comparator_output, capture_filter_enable,
     capture_edge_rising, capture_irq_enable, overflow_irq_enable, capture_flag_clear,
     overflow_flag_clear, capture_irq_ack, overflow_irq_ack} = '0;
    failures = 0;
    n_tests = 0;
    step(6);
    srst = 1'b0;
    t_counter();
    t_tops();
    t_capture();
    t_filter();
    tally_and_finish();
  end
endmodule
`default_nettype wire
